// file: hw/mgmt_interrupt_router.sv
// Overview of operation
// [RQ1] floppy request counts only while enable bit 0 is set
// [RQ2] first serial request counts only while enable bit 1 is set
// [RQ3] second serial request counts only while enable bit 2 is set
// [RQ4] parallel request counts only while enable bit 3 is set
// [RQ5] environment request counts only while enable bit 4 is set
// [RQ6] infrared request counts only while enable bit 5 is set
// [RQ7] music port request counts only while enable bit 6 is set
// [RQ8] enable register at index f0h, resets 00h, bit 7 reserved
// [RQ9] status register at index f2h, resets 00h, shows raised sources
// [RQ10] status bits use the same positions as enables, bit 7 reserved
// [RQ11] pin location register at f5h, resets 00h, bits 5-0 code
// [RQ12] upper three bits pick set 1-5, lower three the pin
// [RQ13] codes 110 000-110 111 map to set 6; others reserved
// [RQ14] event is OR of each request ANDed with its enable
// [RQ15] writing 1 to a status bit clears it
// [RQ16] status bit clears itself once its source goes invalid
// [RQ17] output style selectable: one pulse per event or level
// [RQ18] drive output only on pin of a valid code, else none
`timescale 1ns/1ns
`default_nettype none
module mgmt_interrupt_router
  import mgmt_irq_pkg::*;
#(
  parameter int NSRC = NUM_SRC,
  parameter int PULSE_CYCLES = PULSE_CYC
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire cfg_req_s cfg_req,
  output logic [DATA_W-1:0] cfg_rdata,
  output logic cfg_rvalid,
  input wire logic floppy_irq,
  input wire logic serial_one_irq,
  input wire logic serial_two_irq,
  input wire logic parallel_irq,
  input wire logic environment_irq,
  input wire logic infrared_irq,
  input wire logic music_port_irq,
  output logic mgmt_interrupt_n,
  output logic [NUM_GPIO-1:0] gpio_out,
  output logic [NUM_GPIO-1:0] gpio_oe
);

  // location code to flat pin index, valid flag in top bit
  function automatic logic [LOC_W:0] decode_loc(input logic [LOC_W-1:0] c);
    logic [SET_W-1:0] s;
    s = c[LOC_W-1 -: SET_W];
    decode_loc = '0;
    if (s >= SET_FIRST && s <= SET_LAST) begin // RQ12 RQ13
      decode_loc[LOC_W] = 1'b1;
      decode_loc[LOC_W-1:0] = c - LOC_W'(PINS_PER_SET);
    end
  endfunction

  function automatic logic hit(input cfg_req_s r, input logic [IDX_W-1:0] i);
    hit = (r.logical_device_number == GPIO_DEVICE_NUMBER) && (r.idx == i);
  endfunction

  // source request inputs pass two flops
  logic [NSRC-1:0] src_raw;
  logic [NSRC-1:0] sync1;
  logic [NSRC-1:0] sync2;
  assign src_raw = {music_port_irq, infrared_irq, environment_irq,
                    parallel_irq, serial_two_irq, serial_one_irq, floppy_irq};
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= src_raw;
      sync2 <= sync1;
    end
  end

  // configuration registers
  logic [NSRC-1:0] src_enable;
  logic [NSRC-1:0] src_status;
  logic [LOC_W-1:0] pin_location;
  logic level_style;
  logic [NSRC-1:0] next_src_enable;
  logic [NSRC-1:0] next_src_status;
  logic [LOC_W-1:0] next_pin_location;
  logic next_level_style;
  logic [NSRC-1:0] gated;
  logic [NSRC-1:0] w1c;

  always_comb begin
    next_src_enable = src_enable;
    next_pin_location = pin_location;
    next_level_style = level_style;
    w1c = '0;
    if (cfg_req.wr && hit(cfg_req, IDX_SRC_ENABLE)) begin
      next_src_enable = cfg_req.wdata[NSRC-1:0]; // RQ8
    end
    if (cfg_req.wr && hit(cfg_req, IDX_PIN_LOCATION)) begin
      next_pin_location = cfg_req.wdata[LOC_W-1:0]; // RQ11
    end
    if (cfg_req.wr && hit(cfg_req, IDX_OUT_STYLE)) begin
      next_level_style = cfg_req.wdata[STYLE_LEVEL_BIT]; // RQ17
    end
    if (cfg_req.wr && hit(cfg_req, IDX_SRC_STATUS)) begin
      w1c = cfg_req.wdata[NSRC-1:0];
    end
  end

  // per-source gating and sticky status; set wins over clear
  for (genvar g = 0; g < NSRC; g++) begin : g_src
    // RQ1 RQ2 RQ3 RQ4 RQ5 RQ6 RQ7
    assign gated[g] = sync2[g] & src_enable[g];
    always_comb begin
      if (gated[g]) begin
        next_src_status[g] = 1'b1; // RQ9 RQ10
      end else if (w1c[g] || !sync2[g]) begin
        next_src_status[g] = 1'b0; // RQ15 RQ16
      end else begin
        next_src_status[g] = src_status[g];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      src_enable <= RST_SRC_ENABLE[NSRC-1:0];
      src_status <= RST_SRC_STATUS[NSRC-1:0];
      pin_location <= RST_PIN_LOCATION[LOC_W-1:0];
      level_style <= RST_OUT_STYLE[STYLE_LEVEL_BIT];
    end else begin
      src_enable <= next_src_enable;
      src_status <= next_src_status;
      pin_location <= next_pin_location;
      level_style <= next_level_style;
    end
  end

  // read data, one cycle after the strobe; reserved bits zero
  logic [DATA_W-1:0] next_cfg_rdata;
  always_comb begin
    next_cfg_rdata = '0;
    if (hit(cfg_req, IDX_SRC_ENABLE)) begin
      next_cfg_rdata[NSRC-1:0] = src_enable;
    end else if (hit(cfg_req, IDX_SRC_STATUS)) begin
      next_cfg_rdata[NSRC-1:0] = src_status; // RQ9
    end else if (hit(cfg_req, IDX_PIN_LOCATION)) begin
      next_cfg_rdata[LOC_W-1:0] = pin_location;
    end else if (hit(cfg_req, IDX_OUT_STYLE)) begin
      next_cfg_rdata[STYLE_LEVEL_BIT] = level_style;
    end
    if (!cfg_req.rd) begin
      next_cfg_rdata = '0;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cfg_rdata <= '0;
      cfg_rvalid <= 1'b0;
    end else begin
      cfg_rdata <= next_cfg_rdata;
      cfg_rvalid <= cfg_req.rd;
    end
  end

  // event and output style machine
  logic event_now;
  logic event_prev;
  assign event_now = |gated; // RQ14
  out_state_e state;
  out_state_e next_state;
  logic [PCNT_W-1:0] pcnt;
  logic [PCNT_W-1:0] next_pcnt;
  logic next_irq_active;

  always_comb begin
    next_state = state;
    next_pcnt = pcnt;
    next_irq_active = 1'b0;
    case (state)
      OUT_IDLE: begin
        if (level_style) begin
          next_irq_active = event_now; // RQ17
        end else if (event_now && !event_prev) begin
          next_state = OUT_ACTIVE;
          next_pcnt = PCNT_W'(PULSE_CYCLES - 1);
          next_irq_active = 1'b1;
        end
      end
      OUT_ACTIVE: begin
        if (pcnt == '0) begin
          next_state = OUT_WAIT;
        end else begin
          next_pcnt = pcnt - 1'b1;
          next_irq_active = 1'b1;
        end
      end
      OUT_WAIT: begin
        next_state = OUT_IDLE;
      end
      default: begin
        next_state = OUT_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state <= OUT_IDLE;
      pcnt <= '0;
      event_prev <= 1'b0;
    end else begin
      state <= next_state;
      pcnt <= next_pcnt;
      event_prev <= event_now;
    end
  end

  // pin steering
  logic [LOC_W:0] dec;
  logic [NUM_GPIO-1:0] next_gpio_oe;
  logic [NUM_GPIO-1:0] next_gpio_out;
  logic next_mgmt_n;
  assign dec = decode_loc(pin_location);
  always_comb begin
    next_gpio_oe = '0;
    next_gpio_out = '1;
    next_mgmt_n = !next_irq_active;
    if (dec[LOC_W]) begin
      next_gpio_oe[dec[LOC_W-1:0]] = 1'b1; // RQ18
      next_gpio_out[dec[LOC_W-1:0]] = next_mgmt_n;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      gpio_oe <= '0;
      gpio_out <= '1;
      mgmt_interrupt_n <= 1'b1;
    end else begin
      gpio_oe <= next_gpio_oe;
      gpio_out <= next_gpio_out;
      mgmt_interrupt_n <= next_mgmt_n;
    end
  end

  // checks; a disabled source must never reach the status
  enable_gate_a: assert property (@(posedge clk_sys) disable iff (srst) // RQ1
    !$past(src_enable[SRC_FLOPPY]) && !$past(src_status[SRC_FLOPPY])
    |-> !src_status[SRC_FLOPPY])
    else $error("floppy status set while disabled");
  status_set_a: assert property (@(posedge clk_sys) disable iff (srst) // RQ7
    (sync2[SRC_MUSIC] && src_enable[SRC_MUSIC]) |=> src_status[SRC_MUSIC])
    else $error("music status not set");
  auto_clear_a: assert property (@(posedge clk_sys) disable iff (srst) // RQ16
    !sync2[SRC_PARALLEL] |=> !src_status[SRC_PARALLEL])
    else $error("status kept after source dropped");
  w1c_clear_a: assert property (@(posedge clk_sys) disable iff (srst) // RQ15
    (w1c[SRC_FLOPPY] && !gated[SRC_FLOPPY]) |=> !src_status[SRC_FLOPPY])
    else $error("write one did not clear");
  level_out_a: assert property (@(posedge clk_sys) disable iff (srst) // RQ17
    (level_style && state == OUT_IDLE && event_now) |=> !mgmt_interrupt_n)
    else $error("level output missing");
  pulse_end_a: assert property (@(posedge clk_sys) disable iff (srst) // RQ17
    (!level_style && state == OUT_IDLE && event_now && !event_prev)
    |=> !mgmt_interrupt_n ##1 mgmt_interrupt_n)
    else $error("pulse width wrong");
  no_event_a: assert property (@(posedge clk_sys) disable iff (srst) // RQ14
    (src_enable == '0) [*2] |=> mgmt_interrupt_n)
    else $error("output without enabled source");
  reserved_pin_a: assert property (@(posedge clk_sys) // RQ18
    disable iff (srst)
    (pin_location[LOC_W-1 -: SET_W] == '0) |=> gpio_oe == '0)
    else $error("reserved code drives a pin");
  one_pin_a: assert property (@(posedge clk_sys) disable iff (srst) // RQ18
    $onehot0(gpio_oe))
    else $error("more than one pin driven");
  map_set6_a: assert property (@(posedge clk_sys) disable iff (srst) // RQ13
    (pin_location == 6'h37) |=> gpio_oe[NUM_GPIO-1])
    else $error("set 6 pin 7 not driven");
  map_set1_a: assert property (@(posedge clk_sys) disable iff (srst) // RQ12
    (pin_location == 6'h08) |=> gpio_oe[0])
    else $error("set 1 pin 0 not driven");
  // read path returns the register one cycle later
  read_status_a: assert property (@(posedge clk_sys) disable iff (srst) // RQ9
    (cfg_req.rd && hit(cfg_req, IDX_SRC_STATUS))
    |=> cfg_rdata[NSRC-1:0] == $past(src_status))
    else $error("status read back wrong");
  reserved_bit_a: assert property (@(posedge clk_sys) // RQ10
    disable iff (srst)
    cfg_rvalid |-> !cfg_rdata[DATA_W-1])
    else $error("reserved read bit set");

  // main scenarios reached
  cover_pulse: cover property (@(posedge clk_sys) state == OUT_ACTIVE);
  cover_level: cover property (@(posedge clk_sys)
    level_style && !mgmt_interrupt_n);
  cover_w1c: cover property (@(posedge clk_sys) |w1c && |src_status);
  cover_set6: cover property (@(posedge clk_sys)
    gpio_oe[NUM_GPIO-1] && !gpio_out[NUM_GPIO-1]);

endmodule // mgmt_interrupt_router
`default_nettype wire

// file: include/mgmt_irq_pkg.sv
`default_nettype none
package mgmt_irq_pkg;
  // configuration access
  localparam int IDX_W = 8;
  localparam int DATA_W = 8;
  localparam int DEV_NUM_W = 8;
  localparam logic [DEV_NUM_W-1:0] GPIO_DEVICE_NUMBER = 8'h05;
  localparam logic [IDX_W-1:0] IDX_SRC_ENABLE = 8'hf0;
  localparam logic [IDX_W-1:0] IDX_SRC_STATUS = 8'hf2;
  localparam logic [IDX_W-1:0] IDX_PIN_LOCATION = 8'hf5;
  localparam logic [IDX_W-1:0] IDX_OUT_STYLE = 8'hf7;
  localparam logic [DATA_W-1:0] RST_SRC_ENABLE = 8'h00;
  localparam logic [DATA_W-1:0] RST_SRC_STATUS = 8'h00;
  localparam logic [DATA_W-1:0] RST_PIN_LOCATION = 8'h00;
  localparam logic [DATA_W-1:0] RST_OUT_STYLE = 8'h00;
  // field layout
  localparam int NUM_SRC = 7;
  localparam int SRC_FLOPPY = 0;
  localparam int SRC_SERIAL_ONE = 1;
  localparam int SRC_SERIAL_TWO = 2;
  localparam int SRC_PARALLEL = 3;
  localparam int SRC_ENVIRONMENT = 4;
  localparam int SRC_INFRARED = 5;
  localparam int SRC_MUSIC = 6;
  localparam int LOC_W = 6;
  localparam int SET_W = 3;
  localparam int PIN_W = 3;
  localparam int PINS_PER_SET = 8;
  localparam int NUM_SETS = 6;
  localparam int NUM_GPIO = NUM_SETS * PINS_PER_SET;
  localparam logic [SET_W-1:0] SET_FIRST = 3'h1;
  localparam logic [SET_W-1:0] SET_LAST = 3'h6;
  localparam int STYLE_LEVEL_BIT = 0;
  // pulse style length in clocks
  localparam int PULSE_NS = 10;
  localparam int CLK_NS = 10;
  localparam int PULSE_CYC = (PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int PCNT_W = 4;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [DEV_NUM_W-1:0] logical_device_number;
    logic [IDX_W-1:0] idx;
    logic [DATA_W-1:0] wdata;
  } cfg_req_s;

  typedef enum logic [1:0] {
    OUT_IDLE = 2'b00,
    OUT_ACTIVE = 2'b01,
    OUT_WAIT = 2'b11
  } out_state_e;
endpackage
`default_nettype wire

// file: tb/host_chipset_model.sv
`timescale 1ns/1ns
`default_nettype none
module host_chipset_model
  import mgmt_irq_pkg::*;
(
  input wire logic clk_sys,
  input wire logic clr,
  input wire logic [NUM_GPIO-1:0] gpio_out,
  input wire logic [NUM_GPIO-1:0] gpio_oe,
  output logic [NUM_GPIO-1:0] pin_level,
  output logic [7:0] low_edges
);
  logic prev_all;
  // board pull-ups hold undriven pins high
  always_comb begin
    for (int i = 0; i < NUM_GPIO; i++) begin
      pin_level[i] = gpio_oe[i] ? gpio_out[i] : 1'b1;
    end
  end
  // counts assertions of the interrupt on any pin
  always_ff @(posedge clk_sys) begin
    prev_all <= &pin_level;
    if (clr) begin
      low_edges <= 8'h00;
    end else if (prev_all && !(&pin_level)) begin
      low_edges <= low_edges + 8'h01;
    end
  end
endmodule // host_chipset_model
`default_nettype wire

// file: tb/mgmt_interrupt_router_bench.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) check(n, 48'(e), 48'(g))
module mgmt_interrupt_router_bench;
  import mgmt_irq_pkg::*;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic clr = 1'b1;
  cfg_req_s req = '0;
  logic [6:0] src = '0;
  logic [7:0] cfg_rdata, low_edges;
  logic cfg_rvalid, mgmt_interrupt_n;
  logic [NUM_GPIO-1:0] gpio_out, gpio_oe, pin_level;
  int fails = 0;
  int check_count = 0;
  logic [2:0] s, pn;
  int p;
  // clock at 100 MHz
  always #5 clk_sys = ~clk_sys;
  mgmt_interrupt_router dut_u (.clk_sys(clk_sys), .srst(srst),
    .cfg_req(req), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
    .floppy_irq(src[0]), .serial_one_irq(src[1]),
    .serial_two_irq(src[2]), .parallel_irq(src[3]),
    .environment_irq(src[4]), .infrared_irq(src[5]),
    .music_port_irq(src[6]), .mgmt_interrupt_n(mgmt_interrupt_n),
    .gpio_out(gpio_out), .gpio_oe(gpio_oe));
  host_chipset_model host_u (.clk_sys(clk_sys), .clr(clr),
    .gpio_out(gpio_out), .gpio_oe(gpio_oe), .pin_level(pin_level),
    .low_edges(low_edges));
  task automatic check(string n, logic [47:0] e, logic [47:0] g);
    check_count++;
    if (e !== g) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic finish_test();
    if (fails == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // one-cycle write strobe
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    @(posedge clk_sys);
    req <= '{wr: 1'b1, rd: 1'b0, logical_device_number: GPIO_DEVICE_NUMBER,
             idx: idx, wdata: d};
    @(posedge clk_sys);
    req <= '0;
  endtask
  // read then compare the registered answer
  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] e);
    @(posedge clk_sys);
    req <= '{wr: 1'b0, rd: 1'b1, logical_device_number: GPIO_DEVICE_NUMBER,
             idx: idx, wdata: 8'h00};
    @(posedge clk_sys);
    req <= '0;
    #1;
    `CHK("cfg_rvalid", 1'b1, cfg_rvalid);
    `CHK("cfg_rdata", e, cfg_rdata);
  endtask
  // source levels change only on a rising edge
  task automatic drive_src(input logic [6:0] v);
    @(posedge clk_sys);
    src <= v;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  initial begin
    #200000;
    fails++;
    finish_test();
  end
  initial begin
    repeat (10) @(posedge clk_sys);
    srst <= 1'b0;
    rd_chk(IDX_SRC_ENABLE, 8'h00);
    rd_chk(IDX_SRC_STATUS, 8'h00);
    rd_chk(IDX_PIN_LOCATION, 8'h00);
    rd_chk(8'hf3, 8'h00);
    wr(IDX_SRC_ENABLE, 8'hff);
    rd_chk(IDX_SRC_ENABLE, 8'h7f);
    wr(IDX_PIN_LOCATION, 8'hff);
    rd_chk(IDX_PIN_LOCATION, 8'h3f);
    wr(IDX_OUT_STYLE, 8'h01);
    // each source alone, with a masked neighbour raised first
    for (int i = 0; i < 7; i++) begin
      s = 3'(1 + i % 6);
      pn = (i == 5) ? 3'h7 : 3'(i);
      p = (s - 1) * 8 + pn;
      wr(IDX_PIN_LOCATION, {2'b00, s, pn});
      wr(IDX_SRC_ENABLE, 8'(1 << i));
      src <= 7'(1 << ((i + 1) % 7));
      settle(5);
      `CHK("masked_n", 1'b1, mgmt_interrupt_n);
      rd_chk(IDX_SRC_STATUS, 8'h00);
      drive_src(src | 7'(1 << i));
      settle(5);
      `CHK("level_n", 1'b0, mgmt_interrupt_n);
      `CHK("gpio_oe", 48'h1 << p, gpio_oe);
      `CHK("pin_level", 1'b0, pin_level[p]);
      rd_chk(IDX_SRC_STATUS, 8'(1 << i));
      drive_src(7'h00);
      settle(5);
      rd_chk(IDX_SRC_STATUS, 8'h00);
      `CHK("idle_n", 1'b1, mgmt_interrupt_n);
    end
    // reserved location drives nothing
    wr(IDX_PIN_LOCATION, 8'h38);
    wr(IDX_SRC_ENABLE, 8'h01);
    src <= 7'h01;
    settle(5);
    `CHK("reserved_oe", 48'h0, gpio_oe);
    rd_chk(IDX_SRC_STATUS, 8'h01);
    wr(IDX_SRC_ENABLE, 8'h00);
    wr(IDX_SRC_STATUS, 8'h01);
    rd_chk(IDX_SRC_STATUS, 8'h00);
    // pulse style gives one assertion per event
    drive_src(7'h00);
    wr(IDX_PIN_LOCATION, 8'h08);
    wr(IDX_OUT_STYLE, 8'h00);
    wr(IDX_SRC_ENABLE, 8'h01);
    clr <= 1'b0;
    drive_src(7'h01);
    settle(10);
    `CHK("pulse_count", 8'h01, low_edges);
    `CHK("pulse_n", 1'b1, mgmt_interrupt_n);
    finish_test();
  end
endmodule // mgmt_interrupt_router_bench
`default_nettype wire
